/* File: logic/tfp_cfg.svh */
// Behaviour
// RQ1: Burst count written mid-period is latched only at the next period start.
// RQ2: Software sets the prescaler before starting and never changes it live.
// RQ3: Burst: first pulse at first crossing, then only crossings inside count*Tck.
// RQ4: Burst timing comes from sync A rising and sync B falling edges.
// RQ5: Later burst pulses last Tp and start Tp/2 before the crossing.
// RQ6: Tp is master clock period times the 16-bit width from high and low bytes.
// RQ7: Polarity bit 0 gives positive pulses, 1 negative; change acts at once.
// RQ8: Negative quadrants: set on A rise, clear after Tp; same on B fall.
// RQ9: Burst events: period rise, period fall, and each firing pulse.
// RQ10: Burst with zero width or zero count gives no pulse and no pulse event.
// RQ11: All events always generated; mask field bits 5:3 select delivery.
// RQ12: Phase mode delay T1 is count times master period times prescaler plus one.
// RQ13: Outside circuit aligns A rising and B falling edges with crossings.
// RQ14: Single-sync bit set uses sync A for B and releases the B pin.
// RQ15: Phase mode after T1 emits 8 pulses at 50% duty, halves of width cycles.
// RQ16: Phase mode width is set at start; changing it needs a block reset.
// RQ17: Software keeps T1 plus train inside the first mains half period.
// RQ18: Phase events: A rising, B falling, and first pulse after T1.
// RQ19: Phase mode with zero width keeps output inactive yet raises pulse event.
// RQ20: Mode 00 PWM, 01 burst, 1x phase angle.
// RQ21: Clock source 0 is master clock, 1 is sync A; burst needs 1.
// RQ22: Enable bit 0 holds block in reset and floats the output; 1 releases.
// RQ23: Outside PWM the run bit stays 1; stop and restart only in PWM.
// RQ24: Both sync inputs pass two flip-flops before edge detection.
`ifndef TFP_CFG_SVH
`define TFP_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TFP_OFS_CTRL  32'h0000_0000
`define TFP_OFS_PWH   32'h0000_0004
`define TFP_OFS_PWL   32'h0000_0008
`define TFP_OFS_CNT   32'h0000_000C
`define TFP_OFS_PSC   32'h0000_0010
`define TFP_OFS_CONF0 32'h0000_0014
`define TFP_OFS_STAT  32'h0000_0018

// ----------------------------------------------------------------------
// Decoded register indices
// ----------------------------------------------------------------------
`define TFP_IDX_NONE  3'h0
`define TFP_IDX_CTRL  3'h1
`define TFP_IDX_PWH   3'h2
`define TFP_IDX_PWL   3'h3
`define TFP_IDX_CNT   3'h4
`define TFP_IDX_PSC   3'h5
`define TFP_IDX_CONF0 3'h6
`define TFP_IDX_STAT  3'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TFP_POL_BIT   0
`define TFP_MODE_LSB  2
`define TFP_MODE_MSB  3
`define TFP_CLOCK_SOURCE_SELECT_BIT  4
`define TFP_RUN_BIT   5
`define TFP_SINGLE_SYNC_SELECT_BIT  6
`define TFP_ENA_BIT   7
`define TFP_MSK_PLS   3
`define TFP_MSK_RISE  4
`define TFP_MSK_FALL  5

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define TFP_RST_BYTE  8'h00
`define TFP_RST_PSC   16'h0000
`define TFP_PER_LAST  8'hFE
`define TFP_HALF_LAST 4'hF

`endif

/* File: logic/tfp_pkg.sv */
package tfp_pkg;

	// Operating modes; both codes with the upper bit set are phase mode.
	typedef enum logic [1:0]
	{
		tfp_md_pwm   = 2'b00,
		tfp_md_burst = 2'b01,
		tfp_md_ph0   = 2'b10,
		tfp_md_ph1   = 2'b11
	} tfp_mode_t;

	// Pulse sequencer states.
	typedef enum logic [1:0]
	{
		tfp_st_idle  = 2'b00,
		tfp_st_delay = 2'b01,
		tfp_st_train = 2'b10
	} tfp_state_t;

endpackage

/* File: logic/tfp_sync_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Cleaned mains edges handed from the synchroniser to the sequencer.
interface tfp_sync_if;
	logic rise_a;
	logic fall_b;
	logic lvl_a;
	logic lvl_b;
	modport src (output rise_a, output fall_b, output lvl_a, output lvl_b);
	modport dst (input rise_a, input fall_b, input lvl_a, input lvl_b);
endinterface

`default_nettype wire

/* File: logic/tfp_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module tfp_sync
(
	input  wire logic sys_clk_in,
	input  wire logic resetn_in,
	input  wire logic sync_a_in,
	input  wire logic sync_b_in,
	input  wire logic single_in,
	tfp_sync_if.src   sif
);
	logic [1:0] pin_w;
	logic [1:0] m1_q;
	logic [1:0] m2_q;
	logic [1:0] m3_q;

	assign pin_w = {sync_b_in, sync_a_in};

	// Two stages per pin; the third stage only serves edge detection,
	// so the first stage is never seen by any gate.
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1)
		begin : g_pin
			always_ff @(posedge sys_clk_in)
			begin
				if (!resetn_in)
				begin
					m1_q[i] <= 1'h0;
					m2_q[i] <= 1'h0;
					m3_q[i] <= 1'h0;
				end
				else
				begin
					m1_q[i] <= pin_w[i]; // see RQ24
					m2_q[i] <= m1_q[i];
					m3_q[i] <= m2_q[i];
				end
			end
		end
	endgenerate

	// In single-sync mode the falling edge of A stands in for B.
	assign sif.rise_a = m2_q[0] & ~m3_q[0]; // see RQ4
	assign sif.fall_b = single_in ? (~m2_q[0] & m3_q[0]) // see RQ14
	                              : (~m2_q[1] & m3_q[1]);
	assign sif.lvl_a  = m2_q[0];
	assign sif.lvl_b  = m2_q[1];

endmodule

`default_nettype wire

/* File: logic/tfp_tick_div.sv */
`timescale 1ns/100ps
`default_nettype none

module tfp_tick_div
#(
	parameter int W = 16
)
(
	input  wire logic         sys_clk_in,
	input  wire logic         resetn_in,
	input  wire logic         clr_in,
	input  wire logic         step_in,
	input  wire logic [W-1:0] div_in,
	output logic              tick_out
);
	logic [W-1:0] cnt_q;

	// One tick every div_in+1 steps; the divisor is read live, so a
	// change mid-count can stretch one interval.
	assign tick_out = step_in & (cnt_q == div_in);

	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in || clr_in)
			cnt_q <= '0;
		else if (tick_out)
			cnt_q <= '0;
		else if (step_in)
			cnt_q <= cnt_q + W'(1);
	end

endmodule

`default_nettype wire

/* File: logic/tfp_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tfp_cfg.svh"

module tfp_top
(
	input  wire logic        sys_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic        mains_sync_a_in,
	input  wire logic        mains_sync_b_in,
	output logic             firing_out,
	output logic             firing_oe_out,
	output logic             sync_b_release_out,
	output logic             rise_irq_out,
	output logic             fall_irq_out,
	output logic             pulse_irq_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	function automatic logic [2:0] tfp_reg_idx(input logic [31:0] a);
		logic [2:0] r;
		r = `TFP_IDX_NONE;
		if (a == `TFP_OFS_CTRL)
			r = `TFP_IDX_CTRL;
		if (a == `TFP_OFS_PWH)
			r = `TFP_IDX_PWH;
		if (a == `TFP_OFS_PWL)
			r = `TFP_IDX_PWL;
		if (a == `TFP_OFS_CNT)
			r = `TFP_IDX_CNT;
		if (a == `TFP_OFS_PSC)
			r = `TFP_IDX_PSC;
		if (a == `TFP_OFS_CONF0)
			r = `TFP_IDX_CONF0;
		if (a == `TFP_OFS_STAT)
			r = `TFP_IDX_STAT;
		return r;
	endfunction

	logic        ap_take_w;
	logic [2:0]  ap_idx_q;
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic        hready_q;
	logic        hresp_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_w;
	logic [7:0]  ctrl_q;
	logic [7:0]  pwh_q;
	logic [7:0]  pwl_q;
	logic [7:0]  cnt_q;
	logic [15:0] psc_q;
	logic [7:0]  conf0_q;
	logic [7:0]  stat_w;

	assign ap_take_w = hsel_in & htrans_in[1] & hready_in;

	// Reads take one wait state so a write just before them has landed.
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			wr_pend_q <= 1'h0;
			rd_pend_q <= 1'h0;
			ap_idx_q  <= `TFP_IDX_NONE;
			hready_q  <= 1'h1;
			hresp_q   <= 1'h0;
		end
		else
		begin
			wr_pend_q <= ap_take_w & hwrite_in;
			rd_pend_q <= ap_take_w & ~hwrite_in;
			if (ap_take_w)
				ap_idx_q <= tfp_reg_idx(haddr_in);
			hready_q  <= ~(ap_take_w & ~hwrite_in);
			hresp_q   <= 1'h0;
		end
	end

	// Register writes in the data phase; unmapped writes are dropped.
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			ctrl_q  <= `TFP_RST_BYTE;
			pwh_q   <= `TFP_RST_BYTE;
			pwl_q   <= `TFP_RST_BYTE;
			cnt_q   <= `TFP_RST_BYTE;
			psc_q   <= `TFP_RST_PSC;
			conf0_q <= `TFP_RST_BYTE;
		end
		else if (wr_pend_q)
		begin
			case (ap_idx_q)
				`TFP_IDX_CTRL:  ctrl_q  <= hwdata_in[7:0];
				`TFP_IDX_PWH:   pwh_q   <= hwdata_in[7:0];
				`TFP_IDX_PWL:   pwl_q   <= hwdata_in[7:0];
				`TFP_IDX_CNT:   cnt_q   <= hwdata_in[7:0];
				`TFP_IDX_PSC:   psc_q   <= hwdata_in[15:0]; // see RQ2
				`TFP_IDX_CONF0: conf0_q <= hwdata_in[7:0];
				default:        ;
			endcase
		end
	end

	assign rd_w = (ap_idx_q == `TFP_IDX_CTRL)  ? 32'(ctrl_q)  :
	              (ap_idx_q == `TFP_IDX_PWH)   ? 32'(pwh_q)   :
	              (ap_idx_q == `TFP_IDX_PWL)   ? 32'(pwl_q)   :
	              (ap_idx_q == `TFP_IDX_CNT)   ? 32'(cnt_q)   :
	              (ap_idx_q == `TFP_IDX_PSC)   ? 32'(psc_q)   :
	              (ap_idx_q == `TFP_IDX_CONF0) ? 32'(conf0_q) :
	              (ap_idx_q == `TFP_IDX_STAT)  ? 32'(stat_w)  :
	              32'h0000_0000;

	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
			hrdata_q <= 32'h0000_0000;
		else if (rd_pend_q)
			hrdata_q <= rd_w;
	end

	assign hrdata_out    = hrdata_q;
	assign hreadyout_out = hready_q;
	assign hresp_out     = hresp_q;

	// ------------------------------------------------------------------
	// Decode, synchroniser and prescaler
	// ------------------------------------------------------------------
	tfp_pkg::tfp_mode_t mode_w;
	logic        en_w;
	logic        pwm_w;
	logic        burst_w;
	logic        phase_w;
	logic        pol_w;
	logic [15:0] utp_w;
	logic        zc_w;
	logic        step_w;
	logic        tick_w;

	tfp_sync_if sif ();

	tfp_sync u_sync
	(
		.sys_clk_in (sys_clk_in),
		.resetn_in  (resetn_in),
		.sync_a_in  (mains_sync_a_in),
		.sync_b_in  (mains_sync_b_in),
		.single_in  (ctrl_q[`TFP_SINGLE_SYNC_SELECT_BIT]),
		.sif        (sif.src)
	);

	assign mode_w  = tfp_pkg::tfp_mode_t'(ctrl_q[`TFP_MODE_MSB:`TFP_MODE_LSB]);
	assign en_w    = ctrl_q[`TFP_ENA_BIT]; // see RQ22
	assign pwm_w   = (mode_w == tfp_pkg::tfp_md_pwm); // see RQ20
	assign burst_w = (mode_w == tfp_pkg::tfp_md_burst);
	assign phase_w = ctrl_q[`TFP_MODE_MSB];
	assign pol_w   = ctrl_q[`TFP_POL_BIT];
	assign utp_w   = {pwh_q, pwl_q}; // see RQ6
	assign zc_w    = sif.rise_a | sif.fall_b; // see RQ4, RQ13

	// Phase mode always divides the master clock; elsewhere the source
	// bit picks master clock or mains edges. Only PWM honours the stop.
	assign step_w = (~ctrl_q[`TFP_CLOCK_SOURCE_SELECT_BIT] | phase_w | sif.rise_a) // see RQ21
	              & (ctrl_q[`TFP_RUN_BIT] | ~pwm_w); // see RQ23

	tfp_tick_div #(.W(16)) u_div
	(
		.sys_clk_in (sys_clk_in),
		.resetn_in  (resetn_in),
		.clr_in     (~en_w | (phase_w & zc_w)), // see RQ12
		.step_in    (step_w),
		.div_in     (psc_q),
		.tick_out   (tick_w)
	);

	// ------------------------------------------------------------------
	// Period signal for PWM and burst
	// ------------------------------------------------------------------
	logic [7:0] per_q;
	logic [7:0] lat_q;
	logic       tb_q;
	logic       tb_w;
	logic       wrap_w;

	assign wrap_w = tick_w & ~phase_w & (per_q == `TFP_PER_LAST);
	assign tb_w   = ~phase_w & (per_q < lat_q); // see RQ3

	// The count is sampled only at a period boundary or while disabled.
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			per_q <= `TFP_RST_BYTE;
			lat_q <= `TFP_RST_BYTE;
			tb_q  <= 1'h0;
		end
		else if (!en_w)
		begin
			per_q <= `TFP_RST_BYTE;
			lat_q <= cnt_q;
			tb_q  <= 1'h0;
		end
		else
		begin
			if (wrap_w)
			begin
				per_q <= `TFP_RST_BYTE;
				lat_q <= cnt_q; // see RQ1
			end
			else if (tick_w & ~phase_w)
				per_q <= per_q + 8'h01;
			tb_q <= tb_w;
		end
	end

	property p_lat_hold;
		en_w && !wrap_w |=> lat_q == $past(lat_q);
	endproperty
	a_lat_hold: assert property (p_lat_hold) // see RQ1
		else $error("burst count changed inside a period");

	// ------------------------------------------------------------------
	// Crossing interval measurement for centred burst pulses
	// ------------------------------------------------------------------
	logic [23:0] since_q;
	logic [23:0] hp_q;
	logic [23:0] half_w;
	logic        seen_q;
	logic        hpv_q;
	logic        ctr_ok_w;

	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in || !en_w)
		begin
			since_q <= 24'h00_0000;
			hp_q    <= 24'h00_0000;
			seen_q  <= 1'h0;
			hpv_q   <= 1'h0;
		end
		else if (zc_w)
		begin
			since_q <= 24'h00_0000;
			hp_q    <= since_q;
			seen_q  <= 1'h1;
			hpv_q   <= seen_q;
		end
		else
			since_q <= since_q + 24'(~&since_q);
	end

	// Start Tp/2 ahead of the crossing predicted from the last interval.
	assign half_w   = 24'(utp_w[15:1]);
	assign ctr_ok_w = hpv_q & (hp_q > half_w)
	                & (since_q == hp_q - half_w); // see RQ5

	// ------------------------------------------------------------------
	// Pulse sequencer
	// ------------------------------------------------------------------
	tfp_pkg::tfp_state_t st_q;
	logic [15:0] pt_q;
	logic [7:0]  dly_q;
	logic [3:0]  hv_q;
	logic        pls_q;
	logic        bon_q;
	logic        arm_w;
	logic        bstart_w;
	logic        t1_w;
	logic        raw_w;

	// Negative polarity fires right on each edge; positive fires the
	// first pulse on the edge and centres the rest.
	assign arm_w    = burst_w & tb_w & (utp_w != 16'h0000); // see RQ10
	assign bstart_w = arm_w & ((zc_w & (~bon_q | pol_w)) // see RQ3, RQ8
	                | (bon_q & ~pol_w & ctr_ok_w)); // see RQ5
	assign t1_w     = phase_w & (st_q == tfp_pkg::tfp_st_delay)
	                & (dly_q == cnt_q) & ~zc_w; // see RQ12

	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in || !en_w)
			bon_q <= 1'h0;
		else
			bon_q <= tb_w & (bon_q | bstart_w);
	end

	// A crossing in phase mode restarts the delay even mid-train.
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in || !en_w)
		begin
			st_q  <= tfp_pkg::tfp_st_idle;
			pt_q  <= 16'h0000;
			dly_q <= `TFP_RST_BYTE;
			hv_q  <= 4'h0;
			pls_q <= 1'h0;
		end
		else if (phase_w & zc_w)
		begin
			st_q  <= tfp_pkg::tfp_st_delay;
			dly_q <= `TFP_RST_BYTE;
			pls_q <= 1'h0;
		end
		else
		begin
			case (st_q)
				tfp_pkg::tfp_st_idle:
				begin
					if (bstart_w)
					begin
						pls_q <= 1'h1;
						pt_q  <= utp_w; // see RQ6
					end
					else if (pls_q && pt_q == 16'h0001)
						pls_q <= 1'h0;
					else if (pls_q)
						pt_q <= pt_q - 16'h0001;
				end
				tfp_pkg::tfp_st_delay:
				begin
					if (t1_w)
					begin
						st_q  <= (utp_w != 16'h0000) ? tfp_pkg::tfp_st_train
						                             : tfp_pkg::tfp_st_idle; // see RQ19
						pt_q  <= utp_w;
						hv_q  <= 4'h0;
						pls_q <= (utp_w != 16'h0000);
					end
					else if (tick_w)
						dly_q <= dly_q + 8'h01;
				end
				tfp_pkg::tfp_st_train:
				begin
					if (pt_q == 16'h0001)
					begin
						pt_q  <= utp_w;
						hv_q  <= hv_q + 4'h1;
						pls_q <= ~pls_q; // see RQ15
						if (hv_q == `TFP_HALF_LAST)
						begin
							st_q  <= tfp_pkg::tfp_st_idle;
							pls_q <= 1'h0;
						end
					end
					else
						pt_q <= pt_q - 16'h0001;
				end
				default:
					st_q <= tfp_pkg::tfp_st_idle;
			endcase
		end
	end

	sequence s_last_half;
		st_q == tfp_pkg::tfp_st_train && hv_q == `TFP_HALF_LAST
		&& pt_q == 16'h0001 && !zc_w;
	endsequence
	property p_train_end;
		s_last_half |=> st_q == tfp_pkg::tfp_st_idle && !pls_q;
	endproperty
	a_train_end: assert property (p_train_end) // see RQ15
		else $error("pulse train did not stop after sixteen halves");

	property p_burst_none;
		burst_w && (utp_w == 16'h0000 || lat_q == 8'h00) |-> !bstart_w;
	endproperty
	a_burst_none: assert property (p_burst_none) // see RQ10
		else $error("burst pulse started with zero width or count");

	// Helper counter for the pulse length check.
	logic [15:0] hi_cnt_q;
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
			hi_cnt_q <= 16'h0000;
		else
			hi_cnt_q <= pls_q ? hi_cnt_q + 16'h0001 : 16'h0000;
	end

	property p_pulse_len;
		burst_w && $fell(pls_q) && $stable(utp_w) && en_w
		|-> hi_cnt_q == utp_w;
	endproperty
	a_pulse_len: assert property (p_pulse_len) // see RQ6
		else $error("burst pulse length differs from width value");

	property p_t1_len;
		t1_w |-> {1'h0, since_q} == 25'(cnt_q) * (25'(psc_q) + 25'h1);
	endproperty
	a_t1_len: assert property (p_t1_len) // see RQ12
		else $error("phase delay differs from count times divisor");

	// ------------------------------------------------------------------
	// Output pin and event outputs
	// ------------------------------------------------------------------
	logic fire_q;
	logic oe_q;
	logic rel_q;
	logic rise_q;
	logic fall_q;
	logic plsi_q;
	logic rise_ev_w;
	logic fall_ev_w;
	logic pls_ev_w;

	assign raw_w     = pwm_w ? tb_q : pls_q;
	assign rise_ev_w = phase_w ? sif.rise_a : (tb_w & ~tb_q); // see RQ9, RQ18
	assign fall_ev_w = phase_w ? sif.fall_b : (~tb_w & tb_q);
	assign pls_ev_w  = t1_w | bstart_w; // see RQ18, RQ19

	// Events are always formed; the mask only gates delivery.
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			fire_q <= 1'h0;
			oe_q   <= 1'h0;
			rel_q  <= 1'h0;
			rise_q <= 1'h0;
			fall_q <= 1'h0;
			plsi_q <= 1'h0;
		end
		else
		begin
			fire_q <= raw_w ^ pol_w; // see RQ7
			oe_q   <= en_w; // see RQ22
			rel_q  <= ctrl_q[`TFP_SINGLE_SYNC_SELECT_BIT]; // see RQ14
			rise_q <= en_w & rise_ev_w & conf0_q[`TFP_MSK_RISE]; // see RQ11
			fall_q <= en_w & fall_ev_w & conf0_q[`TFP_MSK_FALL];
			plsi_q <= en_w & pls_ev_w & conf0_q[`TFP_MSK_PLS];
		end
	end

	assign firing_out         = fire_q;
	assign firing_oe_out      = oe_q;
	assign sync_b_release_out = rel_q;
	assign rise_irq_out       = rise_q;
	assign fall_irq_out       = fall_q;
	assign pulse_irq_out      = plsi_q;
	assign stat_w = {sif.lvl_b, sif.lvl_a, st_q, bon_q, tb_q, pls_q, en_w};

	property p_float;
		!en_w |=> !firing_oe_out;
	endproperty
	a_float: assert property (p_float) // see RQ22
		else $error("output driven while block held in reset");

	property p_pol;
		1'h1 |=> firing_out == ($past(raw_w) ^ $past(pol_w));
	endproperty
	a_pol: assert property (p_pol) // see RQ7
		else $error("output level does not follow polarity");

	property p_mask;
		en_w && pls_ev_w |=> pulse_irq_out == $past(conf0_q[`TFP_MSK_PLS]);
	endproperty
	a_mask: assert property (p_mask) // see RQ11
		else $error("pulse event not gated by its mask bit");

	property p_zero_width;
		phase_w && utp_w == 16'h0000 && $stable(utp_w) && $stable(phase_w)
		|=> firing_out == $past(pol_w);
	endproperty
	a_zero_width: assert property (p_zero_width) // see RQ19
		else $error("phase output active with zero width");

	property p_release;
		ctrl_q[`TFP_SINGLE_SYNC_SELECT_BIT] |=> sync_b_release_out;
	endproperty
	a_release: assert property (p_release) // see RQ14
		else $error("second sync pin not released in single mode");

endmodule

`default_nettype wire

/* File: tb/tfp_mains_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Mains zero-crossing circuit and triac gate seen from the pins.
module tfp_mains_model
#(
	parameter int HALF = 100
)
(
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        gate_in,
	output logic             sync_a_out,
	output logic             sync_b_out,
	output logic [15:0]      pulse_cnt_out,
	output logic [15:0]      last_len_out
);
	logic [15:0] ph_q;
	logic [15:0] len_q;
	logic        gate_q;

	// Sync A rises on one crossing and sync B falls on the next one.
	// Both come from the same square wave, so no edge is ever early.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			ph_q       <= 16'h0000;
			sync_a_out <= 1'b0;
			sync_b_out <= 1'b0;
		end
		else
		begin
			ph_q       <= (ph_q == 16'(2 * HALF - 1)) ? 16'h0000 : ph_q + 1'b1;
			sync_a_out <= (ph_q < 16'(HALF));
			sync_b_out <= (ph_q < 16'(HALF));
		end
	end

	// The gate counts active-high pulses and keeps the last pulse length.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			gate_q        <= 1'b0;
			len_q         <= 16'h0000;
			pulse_cnt_out <= 16'h0000;
			last_len_out  <= 16'h0000;
		end
		else
		begin
			gate_q <= gate_in;
			len_q  <= (gate_in && !gate_q) ? 16'h0001 : len_q + gate_in;
			if (gate_in && !gate_q)
				pulse_cnt_out <= pulse_cnt_out + 1'b1;
			if (!gate_in && gate_q)
				last_len_out <= len_q;
		end
	end
endmodule

`default_nettype wire

/* File: tb/triac_firing_pulse_timer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tfp_cfg.svh"

module triac_firing_pulse_timer_tb;
	logic        clk    = 1'b0;
	logic        rst_n  = 1'b0;
	logic        hsel   = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] haddr  = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] rd;
	logic [15:0] c0;
	wire  logic [31:0] hrdata;
	wire  logic [15:0] pcnt;
	wire  logic [15:0] plen;
	wire  logic  hready, hresp, sa, sb, fire, oe, rel, rirq, firq, pirq;
	wire  logic  gate;
	int          err_count   = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          nr = 0;
	int          nf = 0;
	int          np = 0;

	// A pull-down on the gate keeps the triac off while the pin floats.
	assign gate = (oe === 1'b1) ? fire : 1'b0;

	always #2.5 clk = ~clk;

	// Event counters and the hang limit.
	always @(posedge clk)
	begin
		cyc++;
		nr += int'(rirq === 1'b1);
		nf += int'(firq === 1'b1);
		np += int'(pirq === 1'b1);
		if (cyc == 20000)
		begin
			err_count++;
			test_done;
		end
	end

	tfp_top dut (.sys_clk_in(clk), .resetn_in(rst_n), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.mains_sync_a_in(sa), .mains_sync_b_in(sb), .firing_out(fire),
		.firing_oe_out(oe), .sync_b_release_out(rel), .rise_irq_out(rirq),
		.fall_irq_out(firq), .pulse_irq_out(pirq));

	tfp_mains_model #(.HALF(100)) mains (.clk_in(clk), .resetn_in(rst_n),
		.gate_in(gate), .sync_a_out(sa), .sync_b_out(sb),
		.pulse_cnt_out(pcnt), .last_len_out(plen));

	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	// One single AHB transfer; the master waits for hready at each phase.
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		rd = hrdata;
		chk(hresp === 1'b0, "bus response");
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] e,
		input string m);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd === e, m);
	endtask

	// Width and prescaler go in while the block is held in reset.
	task automatic cfg(input logic [7:0] c, input logic [7:0] n,
		input logic [15:0] p, input logic [15:0] w, input logic [7:0] m);
		wr(`TFP_OFS_CTRL, {24'h00_0000, c & 8'h7F});
		wr(`TFP_OFS_PWH, {24'h00_0000, w[15:8]});
		wr(`TFP_OFS_PWL, {24'h00_0000, w[7:0]});
		wr(`TFP_OFS_CNT, {24'h00_0000, n});
		wr(`TFP_OFS_PSC, {16'h0000, p});
		wr(`TFP_OFS_CONF0, {24'h00_0000, m});
		wr(`TFP_OFS_CTRL, {24'h00_0000, c});
		repeat (2) @(posedge clk);
	endtask

	task automatic t_regs;
		chk(oe === 1'b0, "pin driven in reset");
		rchk(`TFP_OFS_CTRL, 32'h0000_0000, "control reset");
		rchk(`TFP_OFS_PWL, 32'h0000_0000, "low width reset");
		wr(`TFP_OFS_PWH, 32'h0000_00A5);
		wr(32'h0000_0020, 32'h0000_00FF);
		rchk(`TFP_OFS_PWH, 32'h0000_00A5, "high width write");
		rchk(32'h0000_0020, 32'h0000_0000, "unmapped read");
		wr(`TFP_OFS_CTRL, 32'h0000_0040);
		repeat (2) @(posedge clk);
		chk(rel === 1'b1 && oe === 1'b0, "sync release");
		$display("test registers done");
	endtask

	// Phase mode: count 4, prescaler 1, width 3, keeps T1 short.
	task automatic t_phase;
		int n;
		int r0;
		int f0;
		int p0;
		cfg(8'hA8, 8'h04, 16'h0001, 16'h0003, 8'h38);
		@(posedge sa);
		@(posedge sa);
		c0 = pcnt;
		r0 = nr;
		f0 = nf;
		p0 = np;
		n = 0;
		while (pirq !== 1'b1 && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		chk(n >= 11 && n <= 13, "firing delay");
		repeat (400 - n) @(posedge clk);
		// Two crossings per mains period, so four trains in the window.
		chk(pcnt - c0 === 16'h0020, "train length");
		chk(plen === 16'h0003, "train half period");
		chk(nr - r0 == 2 && nf - f0 == 2, "edge events");
		chk(np - p0 == 4, "train event");
		$display("test phase done");
	endtask

	// Zero width, negative polarity, events masked, then only the pulse event unmasked.
	task automatic t_quiet;
		int r0;
		int p0;
		cfg(8'hA9, 8'h04, 16'h0001, 16'h0000, 8'h00);
		r0 = nr + nf;
		p0 = np;
		repeat (400)
		begin
			@(posedge clk);
			chk(fire === 1'b1 && oe === 1'b1, "idle level");
		end
		chk(nr + nf == r0 && np == p0, "masked events");
		wr(`TFP_OFS_CONF0, 32'h0000_0008);
		p0 = np;
		repeat (400) @(posedge clk);
		chk(np - p0 == 4, "event with zero width");
		wr(`TFP_OFS_CTRL, 32'h0000_00A8);
		repeat (2) @(posedge clk);
		chk(fire === 1'b0, "polarity change");
		$display("test quiet done");
	endtask

	// Burst on mains ticks, then zero width and zero count.
	task automatic t_burst;
		int p0;
		cfg(8'hB4, 8'h02, 16'h0000, 16'h0004, 8'h38);
		c0 = pcnt;
		p0 = np;
		repeat (1600) @(posedge clk);
		chk(pcnt - c0 >= 16'h0001 && pcnt - c0 <= 16'h0005, "burst");
		chk(plen === 16'h0004, "burst width");
		chk(16'(np - p0) === pcnt - c0, "pulse events");
		for (int i = 0; i < 2; i++)
		begin
			cfg(8'hB4, i ? 8'h00 : 8'h02, 16'h0000,
				i ? 16'h0004 : 16'h0000, 8'h38);
			c0 = pcnt;
			p0 = np;
			repeat (1600) @(posedge clk);
			chk(pcnt === c0 && np == p0, "silent burst");
		end
		wr(`TFP_OFS_CTRL, 32'h0000_0034);
		repeat (2) @(posedge clk);
		chk(oe === 1'b0, "block reset floats pin");
		$display("test burst done");
	endtask

	// PWM on the master clock: the pin is high for count ticks of 255.
	task automatic t_pwm;
		cfg(8'hA0, 8'h40, 16'h0000, 16'h0000, 8'h00);
		repeat (600) @(posedge clk);
		chk(plen === 16'h0040, "pwm on time");
		$display("test pwm done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Reset for sixteen cycles, then the scenarios in turn.
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_phase;
		t_quiet;
		t_burst;
		t_pwm;
		test_done;
	end
endmodule

`default_nettype wire
